// File: pkg/track_mode_map.vh
// constants for the track protocol mode selection block
`ifndef TRACK_MODE_MAP_VH
`define TRACK_MODE_MAP_VH

// ****************************************************************
// register bus offsets (configuration variable numbers)
// ****************************************************************
`define CV_ADDR_SHORT 8'h01
`define CV_ADDR_MAKER 8'h08
`define CV_ADDR_CONFIG 8'h1d
`define CV_ADDR_EXTOPT 8'h31
`define CV_ADDR_STATUS 8'hf0
`define CV_ADDR_LAST 8'hff

// ****************************************************************
// fields and reset values
// ****************************************************************
`define CFG_BIT_STEP28 1
`define CFG_BIT_ANALOG 2
`define EXT_BIT_NOAUTO 4
`define RST_SHORT_ADDR 8'h03
`define RST_CONFIG 8'h04
`define RST_EXTOPT 8'h00
`define RST_CV 8'h00
`define MAKER_CODE 8'h5a
`define SHORT_ADDR_MIN 8'h01
`define SHORT_ADDR_MAX 8'h7f
`define TRI_ADDR_MIN 8'h01
`define TRI_ADDR_MAX 8'hff
`define CV_COUNT 256
`define RST_SPEED 8'h00
`define RST_AUX 4'h0

// ****************************************************************
// speed step modes and track formats
// ****************************************************************
`define STEPS_14 2'h0
`define STEPS_28 2'h1
`define STEPS_128 2'h2
`define FMT_NONE 3'h0
`define FMT_DCC 3'h1
`define FMT_TRI 3'h2
`define FMT_SEC 3'h3
`define FMT_ADC 3'h4
`define FMT_AAC 3'h5

`endif

// File: design/track_protocol_mode_select.v
// track protocol mode selection and configuration variable store
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "track_mode_map.vh"

// Notes on behaviour
// - on each power-up with lighting on, try to find the dcc step mode
// - once settled, keep the found step mode until power is lost
// - bit 4 of variable 49 turns auto-detection off
// - with detection off, bit 1 of variable 29 picks the step mode
// - trinary f1 to f4 act only when sent in the extended variant
// - trinary accepts 28 steps as well as 14, with no setting
// - trinary own address may be 01 up to 255; the code matches it to the short address, which only takes 1 to 127
// - secondary receiver turns off on own dcc or trinary packet
// - secondary receiver turns back on after a power break
// - analogue operation is enabled from reset
// - analogue dc runs with load compensation on
// - analogue ac toggles direction on overvoltage pulse, compensation on
// - every configuration variable holds one byte, 0 to 255
// - values outside a variable's allowed range are rejected
// - identification entries are fixed; writes leave them unchanged
// - variable 1 holds the short address, 1 to 127
// - option variables hold the sum of enabled option bit weights
// - changes during operation take effect at once
// - dcc steps of 14, 28 and 128 follow the station's setting
// - from reset, short address 3 with 14 steps
module track_protocol_mode_select (
  input wire i_sys_clk,
  input wire i_sys_rst,
  // register port
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output wire o_reg_reject,
  // power monitor
  input wire i_power_break,
  // decoded dcc packet
  input wire i_dcc_valid,
  input wire [7:0] i_dcc_addr,
  input wire i_dcc_light,
  input wire i_dcc_light_steady,
  input wire [1:0] i_dcc_steps_seen,
  input wire [7:0] i_dcc_speed,
  // decoded trinary packet
  input wire i_tri_valid,
  input wire [7:0] i_tri_addr,
  input wire i_tri_extended,
  input wire i_tri_step28,
  input wire [3:0] i_tri_func,
  input wire [4:0] i_tri_speed,
  // secondary bus packet
  input wire i_sec_valid,
  input wire [7:0] i_sec_addr,
  // analogue sense
  input wire i_analog_dc,
  input wire i_analog_ac,
  input wire i_ac_reverse_pulse,
  // outputs
  output reg [2:0] o_active_format,
  output reg [1:0] o_speed_steps,
  output reg o_steps_settled,
  output reg o_sec_rx_enable,
  output reg [3:0] o_aux_func,
  output reg o_direction,
  output reg o_load_comp,
  output reg [7:0] o_speed
);

  // ****************************************************************
  // configuration variable store
  // ****************************************************************
  reg [7:0] cv_mem [0:255];
  reg [7:0] next_cv_val;
  reg wr_ok;
  wire [7:0] short_addr;
  wire [7:0] cfg_reg;
  wire [7:0] ext_reg;
  wire auto_off;
  wire [7:0] status_byte;

  assign short_addr = cv_mem[`CV_ADDR_SHORT];
  assign cfg_reg = cv_mem[`CV_ADDR_CONFIG];
  assign ext_reg = cv_mem[`CV_ADDR_EXTOPT];
  assign auto_off = ext_reg[`EXT_BIT_NOAUTO];
  assign status_byte = {o_sec_rx_enable, o_steps_settled, o_speed_steps,
                        1'b0, o_active_format};

  // per-variable range check; maker and status entries are fixed
  always @* begin
    next_cv_val = i_reg_wdata;
    wr_ok = 1'b1;
    if (i_reg_addr == `CV_ADDR_SHORT) begin
      wr_ok = (i_reg_wdata >= `SHORT_ADDR_MIN) &&
              (i_reg_wdata <= `SHORT_ADDR_MAX);
    end else if (i_reg_addr == `CV_ADDR_MAKER ||
                 i_reg_addr == `CV_ADDR_STATUS) begin
      wr_ok = 1'b0;
    end
  end

  assign o_reg_reject = i_reg_wr & ~wr_ok;

  // one generate loop owns every byte so reset and write share a driver
  genvar gi;
  generate
    for (gi = 0; gi < `CV_COUNT; gi = gi + 1) begin : g_cv
      always @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          if (gi == `CV_ADDR_SHORT) begin
            cv_mem[gi] <= `RST_SHORT_ADDR;
          end else if (gi == `CV_ADDR_CONFIG) begin
            cv_mem[gi] <= `RST_CONFIG;
          end else if (gi == `CV_ADDR_EXTOPT) begin
            cv_mem[gi] <= `RST_EXTOPT;
          end else if (gi == `CV_ADDR_MAKER) begin
            cv_mem[gi] <= `MAKER_CODE; // arbitrary value
          end else begin
            cv_mem[gi] <= `RST_CV;
          end
        end else if (i_reg_wr && wr_ok && i_reg_addr == gi) begin
          cv_mem[gi] <= next_cv_val;
        end
      end
    end
  endgenerate

  reg [7:0] next_rdata;

  // read data one cycle after the strobe, status at its own offset
  always @* begin
    next_rdata = `RST_CV;
    if (i_reg_rd) begin
      if (i_reg_addr == `CV_ADDR_STATUS) begin
        next_rdata = status_byte;
      end else begin
        next_rdata = cv_mem[i_reg_addr];
      end
    end
  end

  // zero outside the read slot keeps a stale byte off the bus
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= `RST_CV;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // packet qualification
  // ****************************************************************
  wire dcc_own;
  wire tri_own;
  wire sec_own;
  wire analog_en;

  assign dcc_own = i_dcc_valid && (i_dcc_addr == short_addr);
  // any address from 01 to 255 is legal in trinary
  assign tri_own = i_tri_valid && (i_tri_addr == short_addr) &&
                   (i_tri_addr >= `TRI_ADDR_MIN) &&
                   (i_tri_addr <= `TRI_ADDR_MAX);
  assign sec_own = i_sec_valid && o_sec_rx_enable &&
                   (i_sec_addr == short_addr);
  assign analog_en = cfg_reg[`CFG_BIT_ANALOG];

  // ****************************************************************
  // speed step detection state machine
  // ****************************************************************
  localparam [2:0] ST_SEEK = 3'b001;
  localparam [2:0] ST_LOCK = 3'b010;
  localparam [2:0] ST_FIXED = 3'b100;
  reg [2:0] det_state;
  reg [2:0] next_det_state;
  reg [1:0] found_steps;
  wire [1:0] cfg_steps;

  assign cfg_steps = cfg_reg[`CFG_BIT_STEP28] ? `STEPS_28 : `STEPS_14;

  // a power break reopens the search; detection off bypasses it
  always @* begin
    next_det_state = det_state;
    case (det_state)
      ST_SEEK: begin
        if (auto_off) begin
          next_det_state = ST_FIXED;
        end else if (dcc_own && i_dcc_light && i_dcc_light_steady) begin
          next_det_state = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (auto_off) begin
          next_det_state = ST_FIXED;
        end
      end
      ST_FIXED: begin
        if (!auto_off) begin
          next_det_state = ST_SEEK;
        end
      end
      default: begin
        next_det_state = ST_SEEK;
      end
    endcase
    if (i_power_break) begin
      next_det_state = ST_SEEK;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      det_state <= ST_SEEK;
      found_steps <= `STEPS_14;
    end else begin
      det_state <= next_det_state;
      // the step mode is caught only while seeking, then held
      if (det_state == ST_SEEK && dcc_own && i_dcc_light) begin
        found_steps <= i_dcc_steps_seen;
      end
    end
  end

  // ****************************************************************
  // mode outputs
  // ****************************************************************
  wire use_cfg_steps;

  // with detection off the stored setting shows at once, so a power
  // break never lets the stale detected mode leak out for a cycle
  assign use_cfg_steps = (det_state == ST_FIXED) || auto_off;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_speed_steps <= `STEPS_14;
      o_steps_settled <= 1'b0;
    end else if (use_cfg_steps) begin
      o_speed_steps <= cfg_steps;
      o_steps_settled <= 1'b1;
    end else begin
      o_speed_steps <= found_steps;
      o_steps_settled <= (det_state == ST_LOCK);
    end
  end

  // ****************************************************************
  // format priority
  // ****************************************************************
  wire take_dcc;
  wire take_tri;
  wire take_sec;
  wire take_aac;
  wire take_adc;
  wire take_analog;
  wire take_digital;

  // one winner per cycle: dcc, trinary, secondary, analogue ac, dc
  assign take_dcc = dcc_own;
  assign take_tri = tri_own && !dcc_own;
  assign take_sec = sec_own && !dcc_own && !tri_own;
  assign take_aac = analog_en && i_analog_ac && !dcc_own && !tri_own &&
                    !sec_own;
  assign take_adc = analog_en && i_analog_dc && !i_analog_ac &&
                    !dcc_own && !tri_own && !sec_own;
  assign take_analog = take_aac || take_adc;
  assign take_digital = take_dcc || take_tri;

  // ****************************************************************
  // secondary receiver
  // ****************************************************************
  // a power break wins over an own packet in the same cycle, so the
  // receiver is never left off once the supply came back
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_sec_rx_enable <= 1'b1;
    end else if (i_power_break) begin
      o_sec_rx_enable <= 1'b1;
    end else if (take_digital) begin
      o_sec_rx_enable <= 1'b0;
    end
  end

  // ****************************************************************
  // active format and drive outputs
  // ****************************************************************
  // the last format that spoke stays on show until another one does
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_active_format <= `FMT_NONE;
    end else if (take_dcc) begin
      o_active_format <= `FMT_DCC;
    end else if (take_tri) begin
      o_active_format <= `FMT_TRI;
    end else if (take_sec) begin
      o_active_format <= `FMT_SEC;
    end else if (take_aac) begin
      o_active_format <= `FMT_AAC;
    end else if (take_adc) begin
      o_active_format <= `FMT_ADC;
    end
  end

  // load compensation follows a dcc, trinary or analogue winner: off digital, on analogue; secondary leaves it
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_load_comp <= 1'b0;
    end else if (take_digital) begin
      o_load_comp <= 1'b0;
    end else if (take_analog) begin
      o_load_comp <= 1'b1;
    end
  end

  // trinary 14-step speed halves the range, 28 steps pass through
  wire [7:0] tri_speed_wide;

  assign tri_speed_wide = i_tri_step28 ? {3'h0, i_tri_speed} :
                          {4'h0, i_tri_speed[4:1]};

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_speed <= `RST_SPEED;
    end else if (take_dcc) begin
      o_speed <= i_dcc_speed;
    end else if (take_tri) begin
      o_speed <= tri_speed_wide;
    end
  end

  // basic trinary packets carry no auxiliary functions, so they leave
  // the last extended setting standing
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_aux_func <= `RST_AUX;
    end else if (take_tri && i_tri_extended) begin
      o_aux_func <= i_tri_func;
    end
  end

  // the reverse pulse counts only while analogue ac is in charge; the
  // logic does not check speed, so the train must be stopped first
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_direction <= 1'b0;
    end else if (take_aac && i_ac_reverse_pulse) begin
      o_direction <= ~o_direction;
    end
  end

endmodule

// File: verification/track_mode_checker_assertions.sv
// assertion checker for the track protocol mode selection block
`timescale 1ns/1ps
`include "track_mode_map.vh"
module track_mode_checker (
  input wire i_sys_clk,
  input wire i_sys_rst,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] o_reg_rdata,
  input wire o_reg_reject,
  input wire i_power_break,
  input wire i_dcc_valid,
  input wire [7:0] i_dcc_addr,
  input wire i_tri_valid,
  input wire i_tri_extended,
  input wire [3:0] o_aux_func,
  input wire [1:0] o_speed_steps,
  input wire o_steps_settled,
  input wire o_sec_rx_enable
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  reg [7:0] own;
  wire cv1_wr = i_reg_wr && i_reg_addr == `CV_ADDR_SHORT;
  wire in_rng = i_reg_wdata >= `SHORT_ADDR_MIN &&
    i_reg_wdata <= `SHORT_ADDR_MAX;
  // shadow short address, so packets can be judged as our own
  always @(posedge i_sys_clk) begin
    if (i_sys_rst)
      own <= `RST_SHORT_ADDR;
    else if (cv1_wr && !o_reg_reject)
      own <= i_reg_wdata;
  end
  property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read slot");
  property p_fixed; i_reg_wr && i_reg_addr == `CV_ADDR_MAKER |-> o_reg_reject;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("maker entry write not refused");
  property p_range_rej; cv1_wr && !in_rng |-> o_reg_reject; endproperty
  a_range_rej: assert property (p_range_rej)
    else $error("short address out of range not refused");
  property p_range_ok; cv1_wr && in_rng |-> !o_reg_reject; endproperty
  a_range_ok: assert property (p_range_ok)
    else $error("legal short address refused");
  property p_sec_off;
    i_dcc_valid && i_dcc_addr == own && !i_power_break |=> !o_sec_rx_enable;
  endproperty
  a_sec_off: assert property (p_sec_off)
    else $error("secondary receiver still on after own packet");
  property p_sec_on;
    i_power_break && !i_dcc_valid && !i_tri_valid |=> o_sec_rx_enable;
  endproperty
  a_sec_on: assert property (p_sec_on)
    else $error("secondary receiver not back on after power break");
  // writes may retarget the mode a cycle late, so they are excluded
  property p_lock; o_steps_settled && !i_power_break && !i_reg_wr &&
    !$past(i_reg_wr) |=> $stable(o_speed_steps); endproperty
  a_lock: assert property (p_lock)
    else $error("settled step mode changed");
  property p_aux; i_tri_valid && !i_tri_extended |=> $stable(o_aux_func);
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux functions moved by basic trinary packet");
endmodule
bind track_protocol_mode_select track_mode_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_reg_reject(o_reg_reject),
  .i_power_break(i_power_break), .i_dcc_valid(i_dcc_valid),
  .i_dcc_addr(i_dcc_addr), .i_tri_valid(i_tri_valid),
  .i_tri_extended(i_tri_extended), .o_aux_func(o_aux_func),
  .o_speed_steps(o_speed_steps), .o_steps_settled(o_steps_settled),
  .o_sec_rx_enable(o_sec_rx_enable));

// File: verification/track_station_model.sv
// command station model handing decoded dcc packets to the block
`timescale 1ns/1ps
module track_station_model (
  input wire i_sys_clk,
  input wire i_send,
  input wire [7:0] i_addr,
  input wire i_steady,
  input wire [1:0] i_steps,
  output reg o_dcc_valid = 1'b0,
  output reg [7:0] o_dcc_addr = 8'h00,
  output reg o_dcc_light = 1'b0,
  output reg o_dcc_light_steady = 1'b0,
  output reg [1:0] o_dcc_steps_seen = 2'h0
);
  // fields flip between packets so stale values never help the block
  always @(posedge i_sys_clk) begin
    o_dcc_valid <= i_send;
    o_dcc_addr <= i_send ? i_addr : ~o_dcc_addr;
    o_dcc_light <= i_send | ~o_dcc_light;
    o_dcc_light_steady <= i_send ? i_steady : ~o_dcc_light_steady;
    o_dcc_steps_seen <= i_send ? i_steps : ~o_dcc_steps_seen;
  end
endmodule

// File: verification/track_protocol_mode_select_bench.sv
// self-checking bench for the track protocol mode selection block
`timescale 1ns/1ps
`include "track_mode_map.vh"
module track_protocol_mode_select_bench;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  reg pb = 1'b0, send = 1'b0, tv = 1'b0, tx = 1'b0;
  reg sv = 1'b0, adc = 1'b0, aac = 1'b0, arp = 1'b0;
  reg [7:0] addr = 8'h00, wd = 8'h00, dsp = 8'h00, cur;
  reg [1:0] stp = 2'h0;
  reg [3:0] tf = 4'h0;
  reg [31:0] seed = 32'hf832;
  integer bad_count = 0, n_compared = 0, i;
  logic [7:0] expq [$];
  wire dv, dl, dls, settled, sec, rej, lc, dir;
  wire [7:0] da, rdata, spd;
  wire [2:0] fmt;
  wire [1:0] dss, ss;
  wire [3:0] aux;
  track_station_model u_track_station_model (.i_sys_clk(clk),
    .i_send(send), .i_addr(8'h05), .i_steady(1'b1), .i_steps(stp),
    .o_dcc_valid(dv), .o_dcc_addr(da), .o_dcc_light(dl),
    .o_dcc_light_steady(dls), .o_dcc_steps_seen(dss));
  track_protocol_mode_select u_track_protocol_mode_select (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_reject(rej),
    .i_power_break(pb), .i_dcc_valid(dv), .i_dcc_addr(da),
    .i_dcc_light(dl), .i_dcc_light_steady(dls), .i_dcc_steps_seen(dss),
    .i_dcc_speed(dsp), .i_tri_valid(tv), .i_tri_addr(8'h05),
    .i_tri_extended(tx), .i_tri_step28(tf[0]), .i_tri_func(tf),
    .i_tri_speed(dsp[4:0]), .i_sec_valid(sv), .i_sec_addr(8'h05),
    .i_analog_dc(adc), .i_analog_ac(aac), .i_ac_reverse_pulse(arp),
    .o_active_format(fmt), .o_speed_steps(ss), .o_steps_settled(settled),
    .o_sec_rx_enable(sec), .o_aux_func(aux), .o_direction(dir),
    .o_load_comp(lc), .o_speed(spd));
  always #5 clk = ~clk;
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task stop_test;
    begin
      if (bad_count == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wcv(input [7:0] a, input [7:0] d, input e_rej);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      chk(rej, e_rej);
      wr <= 1'b0;
    end
  endtask
  task rcv(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      expq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
  // out of range short addresses must leave the old one standing
  task cv1(input [7:0] w);
    reg ok;
    begin
      ok = w >= `SHORT_ADDR_MIN && w <= `SHORT_ADDR_MAX;
      if (ok)
        cur = w;
      wcv(`CV_ADDR_SHORT, w, !ok);
      rcv(`CV_ADDR_SHORT, cur);
    end
  endtask
  // one event: 0 dcc, 1 trinary, 2 power break, 3 secondary, else reverse
  task pulse(input integer k);
    begin
      @(posedge clk);
      if (k == 0) send <= 1'b1;
      else if (k == 1) tv <= 1'b1;
      else if (k == 2) pb <= 1'b1;
      else if (k == 3) sv <= 1'b1;
      else arp <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      tv <= 1'b0;
      pb <= 1'b0;
      sv <= 1'b0;
      arp <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  // read data stand one cycle after the strobe; oldest note first
  always @(posedge clk) begin
    if (rd_d) chk(rdata, expq.pop_front());
    rd_d <= rd;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cur = `RST_SHORT_ADDR;
    #1;
    chk(ss, `STEPS_14);
    chk(sec, 1'b1);
    rcv(`CV_ADDR_SHORT, `RST_SHORT_ADDR);
    rcv(`CV_ADDR_CONFIG, `RST_CONFIG);
    cv1(8'h00);
    cv1(8'h80);
    cv1(8'h7f);
    cv1(8'h01);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      dsp <= seed[31:24];
      cv1(seed[7:0]);
      wcv(`CV_ADDR_MAKER, seed[15:8], 1'b1);
      rcv(`CV_ADDR_MAKER, `MAKER_CODE);
      wcv(8'hc8, seed[23:16], 1'b0);
      rcv(8'hc8, seed[23:16]);
    end
    cv1(8'h05);
    stp <= `STEPS_28;
    pulse(0);
    chk(ss, `STEPS_28);
    chk(sec, 1'b0);
    chk(fmt, `FMT_DCC);
    chk(spd, dsp);
    stp <= `STEPS_128;
    pulse(0);
    chk(ss, `STEPS_28);
    for (i = 0; i < 3; i = i + 1) begin
      stp <= i[1:0];
      pulse(2);
      chk(sec, 1'b1);
      pulse(0);
      chk(ss, i[1:0]);
    end
    wcv(`CV_ADDR_EXTOPT, 8'h10, 1'b0);
    wcv(`CV_ADDR_CONFIG, 8'h06, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(ss, `STEPS_28);
    rcv(`CV_ADDR_CONFIG, 8'h06);
    wcv(`CV_ADDR_CONFIG, `RST_CONFIG, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(ss, `STEPS_14);
    pulse(2);
    chk(ss, `STEPS_14);
    chk(sec, 1'b1);
    pulse(3);
    chk(fmt, `FMT_SEC);
    tf <= 4'h5;
    pulse(1);
    chk(aux, 4'h0);
    chk(sec, 1'b0);
    chk(fmt, `FMT_TRI);
    chk(spd, {3'h0, dsp[4:0]});
    pulse(3);
    chk(fmt, `FMT_TRI);
    tx <= 1'b1;
    tf <= 4'ha;
    pulse(1);
    chk(aux, 4'ha);
    chk(spd, {4'h0, dsp[4:1]});
    // analogue levels: dc first, then ac on top of it
    adc <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(fmt, `FMT_ADC);
    chk(lc, 1'b1);
    aac <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(fmt, `FMT_AAC);
    chk(dir, 1'b0);
    pulse(4);
    chk(dir, 1'b1);
    chk(lc, 1'b1);
    rcv(`CV_ADDR_STATUS, {1'b0, 1'b1, `STEPS_14, 1'b0, `FMT_AAC});
    wcv(`CV_ADDR_STATUS, 8'h00, 1'b1);
    // analogue switched off: the reverse pulse must be ignored
    wcv(`CV_ADDR_CONFIG, 8'h00, 1'b0);
    pulse(4);
    chk(dir, 1'b1);
    stop_test;
  end
endmodule
